// >>> core/scsd_regs.vh
// Register offsets, field positions, reset values and timing for the clock select block.
// Assumes a 32-bit AXI4-Lite slave with byte addressing and a 100 MHz core clock.
`ifndef SCSD_REGS_VH
`define SCSD_REGS_VH

// Register byte offsets.
`define SCSD_OFF_CTRL      8'h00
`define SCSD_OFF_STAT      8'h04
`define SCSD_OFF_LFSEL     8'h08
`define SCSD_OFF_TRIM      8'h0C

// Control register fields.
`define SCSD_CTRL_MODE_LSB 0
`define SCSD_CTRL_MODE_MSB 1
`define SCSD_CTRL_REQ      2
`define SCSD_CTRL_SLEEP    3
`define SCSD_CTRL_DIV_LSB  4
`define SCSD_CTRL_DIV_MSB  6

// High-speed switch-over modes.
`define SCSD_MODE_AUTO     2'h0
`define SCSD_MODE_SW       2'h1
`define SCSD_MODE_RC       2'h2

// Low-speed clock sources.
`define SCSD_LF_RC         2'h0
`define SCSD_LF_XTAL       2'h1
`define SCSD_LF_EXT        2'h2

// Reset values.
`define SCSD_MODE_RST      2'h0
`define SCSD_DIV_RST       3'h0
`define SCSD_TRIM_RST      8'h00

// Divider select range: 0 gives 100 MHz, 5 gives 3.125 MHz.
`define SCSD_DIV_MAX       3'h5

// Timing: clock rate and the dead time around a source change.
`define SCSD_CLK_MHZ       100
`define SCSD_GATE_NS       40

// Bus responses.
`define SCSD_RESP_OKAY     2'h0
`define SCSD_RESP_SLVERR   2'h2

`endif

// >>> core/scsd_top.v
// Clock select and divide controller with an AXI4-Lite register slave.
// Assumes the core clock stands for the selected high-speed clock; the oscillator ready
// flag and wake pin arrive asynchronously and are synchronised here.
`timescale 1ns/1ns
`include "scsd_regs.vh"
module scsd_top #(
	parameter ADDR_W = 8,
	parameter TRIM_W = 8
) (
	input  wire              core_clk,
	input  wire              rst,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	output wire [1:0]        s_axi_bresp,
	output wire              s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output wire [31:0]       s_axi_rdata,
	output wire [1:0]        s_axi_rresp,
	output wire              s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              xtal_ready_pin,
	input  wire              wake_pin,
	output wire              hs_rc_osc_en,
	output wire              hs_xtal_osc_en,
	output wire              hs_src_xtal,
	output wire              hs_clk_gate,
	output wire              radio_clk_en,
	output wire              periph_clk_en,
	output wire              cpu_clk_en,
	output wire [1:0]        lf_src_sel,
	output wire [TRIM_W-1:0] rc_trim
);
	localparam GATE_CYC = (`SCSD_GATE_NS * `SCSD_CLK_MHZ + 999) / 1000;
	localparam [4:0] ST_RC    = 5'h01;
	localparam [4:0] ST_GATE  = 5'h02;
	localparam [4:0] ST_XTAL  = 5'h04;
	localparam [4:0] ST_SLEEP = 5'h08;
	localparam [4:0] ST_WAKE  = 5'h10;
	localparam [3:0] GATE_LAST = GATE_CYC[3:0] - 4'h1;

	// Out-of-range divider selects saturate at the slowest rate.
	function [2:0] clamp_div;
		input [2:0] sel;
		begin
			clamp_div = (sel > `SCSD_DIV_MAX) ? `SCSD_DIV_MAX : sel;
		end
	endfunction

	reg              awready_reg;
	reg              wready_reg;
	reg              bvalid_reg;
	reg [1:0]        bresp_reg;
	reg              arready_reg;
	reg              rvalid_reg;
	reg [1:0]        rresp_reg;
	reg [31:0]       rdata_reg;
	reg              aw_held_reg;
	reg              w_held_reg;
	reg [ADDR_W-1:0] waddr_reg;
	reg [7:0]        wbyte_reg;
	reg              wlane_reg;
	reg [1:0]        mode_reg;
	reg [2:0]        div_req_reg;
	reg              req_pend_reg;
	reg              sleep_pulse_reg;
	reg [1:0]        lf_src_reg;
	reg              lf_lock_reg;
	reg [1:0]        sync1_reg;
	reg [1:0]        sync2_reg;
	reg [1:0]        sync3_reg;
	reg [1:0]        filt_reg;
	reg [4:0]        state_reg;
	reg [3:0]        gate_cnt_reg;
	reg              rc_en_reg;
	reg              xtal_en_reg;
	reg              src_xtal_reg;
	reg              gate_reg;
	reg              radio_en_reg;
	reg              periph_en_reg;
	reg              cpu_en_reg;
	reg [2:0]        div_act_reg;
	reg [4:0]        div_cnt_reg;
	reg [31:0]       rd_word;
	reg              rd_hit;
	wire [1:0]       agree;
	wire             xtal_ok;
	wire             wake_ok;
	wire             do_write;
	wire             wr_ctrl;
	wire             wr_lf;
	wire             wr_trim;
	wire [TRIM_W-1:0] trim_q;

	// Three-stage synchroniser; a level is taken once the second and third stages agree.
	assign agree   = ~(sync2_reg ^ sync3_reg);
	assign xtal_ok = filt_reg[0];
	assign wake_ok = filt_reg[1];

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
			sync3_reg <= 2'h0;
			filt_reg  <= 2'h0;
		end
		else
		begin
			sync1_reg <= {wake_pin, xtal_ready_pin};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			filt_reg  <= (sync2_reg & agree) | (filt_reg & ~agree);
		end
	end

	// Write channel: address and data are taken in either order, then applied together.
	assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
	assign wr_ctrl  = do_write & wlane_reg & (waddr_reg == `SCSD_OFF_CTRL);
	assign wr_lf    = do_write & wlane_reg & (waddr_reg == `SCSD_OFF_LFSEL);
	assign wr_trim  = do_write & wlane_reg & (waddr_reg == `SCSD_OFF_TRIM);

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			waddr_reg   <= {ADDR_W{1'b0}};
			wbyte_reg   <= 8'h00;
			wlane_reg   <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `SCSD_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && awready_reg)
			begin
				awready_reg <= 1'b0;
				aw_held_reg <= 1'b1;
				waddr_reg   <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
			end
			if (s_axi_wvalid && wready_reg)
			begin
				wready_reg <= 1'b0;
				w_held_reg <= 1'b1;
				wbyte_reg  <= s_axi_wdata[7:0];
				wlane_reg  <= s_axi_wstrb[0];
			end
			if (do_write)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= (waddr_reg == `SCSD_OFF_CTRL || waddr_reg == `SCSD_OFF_STAT ||
					waddr_reg == `SCSD_OFF_LFSEL || waddr_reg == `SCSD_OFF_TRIM) ?
					`SCSD_RESP_OKAY : `SCSD_RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready)
			begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// Read decode; unmapped words read as zero and answer with an error.
	always @*
	begin
		rd_word = 32'h00000000;
		rd_hit  = 1'b1;
		case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
			`SCSD_OFF_CTRL:  rd_word = {25'h0, div_req_reg, 1'b0, req_pend_reg, mode_reg};
			`SCSD_OFF_STAT:  rd_word = {22'h0, lf_src_reg, 1'b0, div_act_reg,
				state_reg == ST_SLEEP, state_reg == ST_GATE, xtal_ok, src_xtal_reg};
			`SCSD_OFF_LFSEL: rd_word = {23'h0, lf_lock_reg, 6'h00, lf_src_reg};
			`SCSD_OFF_TRIM:  rd_word = {{(32-TRIM_W){1'b0}}, trim_q};
			default:         rd_hit  = 1'b0;
		endcase
	end

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= `SCSD_RESP_OKAY;
			rdata_reg   <= 32'h00000000;
		end
		else if (s_axi_arvalid && arready_reg)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_word;
			rresp_reg   <= rd_hit ? `SCSD_RESP_OKAY : `SCSD_RESP_SLVERR;
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// Software control fields and the low-speed source latch.
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mode_reg        <= `SCSD_MODE_RST;
			div_req_reg     <= `SCSD_DIV_RST;
			sleep_pulse_reg <= 1'b0;
			lf_src_reg      <= `SCSD_LF_RC;
			lf_lock_reg     <= 1'b0;
		end
		else
		begin
			sleep_pulse_reg <= wr_ctrl & wbyte_reg[`SCSD_CTRL_SLEEP];
			if (wr_ctrl)
			begin
				mode_reg    <= wbyte_reg[`SCSD_CTRL_MODE_MSB:`SCSD_CTRL_MODE_LSB];
				div_req_reg <= clamp_div(wbyte_reg[`SCSD_CTRL_DIV_MSB:`SCSD_CTRL_DIV_LSB]);
			end
			// Once a non-default source is taken the field is frozen until reset.
			if (wr_lf && !lf_lock_reg && wbyte_reg[1:0] != 2'h3)
			begin
				lf_src_reg  <= wbyte_reg[1:0];
				lf_lock_reg <= (wbyte_reg[1:0] != `SCSD_LF_RC);
			end
		end
	end

	// Switch request flag; a new request in the cycle it is consumed wins.
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			req_pend_reg <= 1'b0;
		else if (wr_ctrl && wbyte_reg[`SCSD_CTRL_REQ])
			req_pend_reg <= 1'b1;
		else if (state_reg != ST_RC)
			req_pend_reg <= 1'b0;
	end

	// High-speed source sequencer. The clock is gated off for a dead time before the source
	// flips and for one cycle after, trading a few lost cycles for a runt-free switch.
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg    <= ST_RC;
			gate_cnt_reg <= 4'h0;
			rc_en_reg    <= 1'b1;
			xtal_en_reg  <= 1'b1;
			src_xtal_reg <= 1'b0;
			gate_reg     <= 1'b1;
		end
		else if (sleep_pulse_reg)
		begin
			state_reg   <= ST_SLEEP;
			gate_reg    <= 1'b0;
			rc_en_reg   <= 1'b0;
			xtal_en_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_RC:
				begin
					gate_reg    <= 1'b1;
					xtal_en_reg <= (mode_reg != `SCSD_MODE_RC);
					if (xtal_ok && xtal_en_reg &&
						(mode_reg == `SCSD_MODE_AUTO ||
						(mode_reg == `SCSD_MODE_SW && req_pend_reg)))
					begin
						state_reg    <= ST_GATE;
						gate_reg     <= 1'b0;
						gate_cnt_reg <= 4'h0;
					end
				end
				ST_GATE:
				begin
					gate_cnt_reg <= gate_cnt_reg + 4'h1;
					if (gate_cnt_reg == GATE_LAST)
					begin
						src_xtal_reg <= 1'b1;
						state_reg    <= ST_XTAL;
					end
				end
				ST_XTAL:
				begin
					gate_reg  <= 1'b1;
					rc_en_reg <= 1'b0;
				end
				ST_SLEEP:
				begin
					if (wake_ok)
					begin
						state_reg    <= ST_WAKE;
						rc_en_reg    <= 1'b1;
						src_xtal_reg <= 1'b0;
						gate_cnt_reg <= 4'h0;
					end
				end
				ST_WAKE:
				begin
					// Give the RC oscillator the dead time before opening the gate.
					gate_cnt_reg <= gate_cnt_reg + 4'h1;
					if (gate_cnt_reg == GATE_LAST)
					begin
						state_reg   <= ST_RC;
						xtal_en_reg <= (mode_reg != `SCSD_MODE_RC);
					end
				end
				default:
				begin
					state_reg    <= ST_RC;
					src_xtal_reg <= 1'b0;
					rc_en_reg    <= 1'b1;
				end
			endcase
		end
	end

	// Clock enables derived from the gated high-speed clock. The processor divider
	// only takes a new rate at the end of a full output period.
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			radio_en_reg  <= 1'b0;
			periph_en_reg <= 1'b0;
			cpu_en_reg    <= 1'b0;
			div_act_reg   <= `SCSD_DIV_RST;
			div_cnt_reg   <= 5'h00;
		end
		else if (!gate_reg)
		begin
			radio_en_reg  <= 1'b0;
			periph_en_reg <= 1'b0;
			cpu_en_reg    <= 1'b0;
		end
		else
		begin
			radio_en_reg  <= 1'b1;
			periph_en_reg <= ~periph_en_reg;
			if (div_cnt_reg == 5'h00)
			begin
				cpu_en_reg  <= 1'b1;
				div_act_reg <= div_req_reg;
				div_cnt_reg <= (5'h01 << div_req_reg) - 5'h01;
			end
			else
			begin
				cpu_en_reg  <= 1'b0;
				div_cnt_reg <= div_cnt_reg - 5'h01;
			end
		end
	end

	// Calibration is held in its own store, untouched by sleep or rate changes.
	scsd_trim_store #(
		.WIDTH   (TRIM_W)
	) u_trim (
		.core_clk(core_clk),
		.rst     (rst),
		.wr_en   (wr_trim),
		.wr_data (wbyte_reg[TRIM_W-1:0]),
		.rd_data (trim_q)
	);

	assign s_axi_awready  = awready_reg;
	assign s_axi_wready   = wready_reg;
	assign s_axi_bresp    = bresp_reg;
	assign s_axi_bvalid   = bvalid_reg;
	assign s_axi_arready  = arready_reg;
	assign s_axi_rdata    = rdata_reg;
	assign s_axi_rresp    = rresp_reg;
	assign s_axi_rvalid   = rvalid_reg;
	assign hs_rc_osc_en   = rc_en_reg;
	assign hs_xtal_osc_en = xtal_en_reg;
	assign hs_src_xtal    = src_xtal_reg;
	assign hs_clk_gate    = gate_reg;
	assign radio_clk_en   = radio_en_reg;
	assign periph_clk_en  = periph_en_reg;
	assign cpu_clk_en     = cpu_en_reg;
	assign lf_src_sel     = lf_src_reg;
	assign rc_trim        = trim_q;
endmodule

// >>> core/scsd_trim_store.v
// One-word store for the high-speed RC oscillator calibration value.
// Assumes writes come from the register slave on the same clock; read data is registered.
`timescale 1ns/1ns
`include "scsd_regs.vh"
module scsd_trim_store #(
	parameter WIDTH = 8
) (
	input  wire             core_clk,
	input  wire             rst,
	input  wire             wr_en,
	input  wire [WIDTH-1:0] wr_data,
	output wire [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem_reg;
	reg [WIDTH-1:0] rd_data_reg;

	// Only a write or reset changes the word, so disabling the oscillator or sleeping keeps it.
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mem_reg     <= `SCSD_TRIM_RST;
			rd_data_reg <= `SCSD_TRIM_RST;
		end
		else
		begin
			if (wr_en)
				mem_reg <= wr_data;
			rd_data_reg <= mem_reg;
		end
	end

	assign rd_data = rd_data_reg;
endmodule

// >>> sim/scsd_top_sva.sv
// Concurrent checks on the ports of the clock select and divide block.
// Assumes the single core_clk domain and the active-high asynchronous reset rst.
`timescale 1ns/1ns
`include "scsd_regs.vh"
module scsd_top_sva #(
	parameter TRIM_W = 8
) (
	input wire              core_clk,
	input wire              rst,
	input wire              s_axi_bvalid,
	input wire              xtal_ready_pin,
	input wire              hs_rc_osc_en,
	input wire              hs_xtal_osc_en,
	input wire              hs_src_xtal,
	input wire              hs_clk_gate,
	input wire              radio_clk_en,
	input wire              periph_clk_en,
	input wire              cpu_clk_en,
	input wire [1:0]        lf_src_sel,
	input wire [TRIM_W-1:0] rc_trim
);
	// All checks share the core clock and are off while reset is held.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_reset_on_rc: assert property ($fell(rst) |-> !hs_src_xtal && hs_rc_osc_en)
		else $error("high-speed source not RC after reset");
	// The radio enable follows the gate by one cycle; the edge after reset is skipped.
	a_radio_full: assert property (!$past(rst) |-> radio_clk_en == $past(hs_clk_gate))
		else $error("radio enable missing while gate open");
	a_periph_half: assert property (hs_clk_gate [*3] |-> periph_clk_en != $past(periph_clk_en))
		else $error("peripheral enable not toggling");
	a_cpu_gated: assert property (cpu_clk_en |-> $past(hs_clk_gate))
		else $error("cpu enable while gate closed");
	// The filter saw the pin high three or four cycles before the decision, which itself
	// comes four gate cycles plus one before the source flag is seen high.
	a_xtal_after_ready: assert property ($rose(hs_src_xtal) |->
		($past(xtal_ready_pin, 8) || $past(xtal_ready_pin, 9)) && hs_xtal_osc_en)
		else $error("crystal chosen without ready flag");
	a_switch_dead: assert property ($changed(hs_src_xtal) |-> !hs_clk_gate && $past(hs_clk_gate) == 1'b0)
		else $error("source changed while gate open");
	a_gate_reopen: assert property ($rose(hs_src_xtal) |-> ##1 hs_clk_gate)
		else $error("gate not reopened after switch");
	a_gate_source_on: assert property (hs_clk_gate |-> (hs_src_xtal ? hs_xtal_osc_en : hs_rc_osc_en))
		else $error("gate open on a stopped oscillator");
	a_lf_one_way: assert property ($changed(lf_src_sel) |-> $past(lf_src_sel) == `SCSD_LF_RC && lf_src_sel != 2'h3)
		else $error("low-speed source left its choice");
	// A stored trim only moves around a bus write, allowing for the store's lag.
	a_trim_hold: assert property (!(s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3)) |-> $stable(rc_trim))
		else $error("trim value changed without a write");
endmodule

bind scsd_top scsd_top_sva #(.TRIM_W(TRIM_W)) u_sva (.core_clk(core_clk), .rst(rst),
	.s_axi_bvalid(s_axi_bvalid), .xtal_ready_pin(xtal_ready_pin), .hs_rc_osc_en(hs_rc_osc_en),
	.hs_xtal_osc_en(hs_xtal_osc_en), .hs_src_xtal(hs_src_xtal), .hs_clk_gate(hs_clk_gate),
	.radio_clk_en(radio_clk_en), .periph_clk_en(periph_clk_en), .cpu_clk_en(cpu_clk_en),
	.lf_src_sel(lf_src_sel), .rc_trim(rc_trim));

// >>> sim/scsd_top_tb.sv
// Self-checking bench for the clock select and divide block, driven over AXI4-Lite.
// Assumes a 100 MHz core clock and the register map of the block's header.
`timescale 1ns/1ns
`include "scsd_regs.vh"
module scsd_top_tb;
	logic        core_clk, rst, xtal_ready_pin, wake_pin;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp, lf_src_sel;
	wire  [31:0] s_axi_rdata;
	wire         hs_rc_osc_en, hs_xtal_osc_en, hs_src_xtal, hs_clk_gate;
	wire         radio_clk_en, periph_clk_en, cpu_clk_en;
	wire  [7:0]  rc_trim;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	logic [31:0] d;
	logic [1:0]  r;

	scsd_top uut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .xtal_ready_pin(xtal_ready_pin), .wake_pin(wake_pin),
		.hs_rc_osc_en(hs_rc_osc_en), .hs_xtal_osc_en(hs_xtal_osc_en), .hs_src_xtal(hs_src_xtal),
		.hs_clk_gate(hs_clk_gate), .radio_clk_en(radio_clk_en), .periph_clk_en(periph_clk_en),
		.cpu_clk_en(cpu_clk_en), .lf_src_sel(lf_src_sel), .rc_trim(rc_trim));

	// Free-running core clock.
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		begin
			cmp_count++;
			if (g !== e)
			begin
				n_mismatch++;
				$display("wrong value %s expected %h seen %h", nm, e, g);
			end
		end
	endtask

	task tally_and_finish;
		begin
			$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
			if (n_mismatch == 0 && cmp_count > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask

	// One write; an edge passes first so no strobe is assigned twice in a step.
	task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		begin
			@(posedge core_clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			rs = 2'h3;
			n = 0;
			while (rs === 2'h3 && n < 50)
			begin
				@(posedge core_clk);
				n++;
				if (s_axi_awready === 1'b1)
					s_axi_awvalid <= 1'b0;
				if (s_axi_wready === 1'b1)
					s_axi_wvalid <= 1'b0;
				if (s_axi_bvalid === 1'b1)
				begin
					rs = s_axi_bresp;
					s_axi_bready <= 1'b0;
				end
			end
			chk("wr_answer", 1'b1, rs !== 2'h3);
		end
	endtask

	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		begin
			@(posedge core_clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			rs = 2'h3;
			n = 0;
			while (rs === 2'h3 && n < 50)
			begin
				@(posedge core_clk);
				n++;
				if (s_axi_arready === 1'b1)
					s_axi_arvalid <= 1'b0;
				if (s_axi_rvalid === 1'b1)
				begin
					rs = s_axi_rresp;
					v = s_axi_rdata;
					s_axi_rready <= 1'b0;
				end
			end
			chk("rd_answer", 1'b1, rs !== 2'h3);
		end
	endtask

	task wr_ok(input logic [7:0] a, input logic [31:0] v);
		begin
			wr(a, v, r);
			chk("bresp", `SCSD_RESP_OKAY, r);
		end
	endtask

	// Bounded wait for the source flag to reach a level.
	task wait_src(input logic lv);
		int n;
		begin
			n = 0;
			while (hs_src_xtal !== lv && n < 40)
			begin
				@(posedge core_clk);
				n++;
			end
		end
	endtask

	// Syncs to a cpu pulse, then counts cycles to the next one.
	task cpu_period(output int p);
		int n;
		begin
			n = 0;
			p = 0;
			do begin @(posedge core_clk); n++; end while (cpu_clk_en !== 1'b1 && n < 80);
			do begin @(posedge core_clk); p++; end while (cpu_clk_en !== 1'b1 && p < 80);
		end
	endtask

	task t_reset_state;
		begin
			chk("src_xtal", 1'b0, hs_src_xtal);
			chk("rc_en", 1'b1, hs_rc_osc_en);
			chk("lf_sel", `SCSD_LF_RC, lf_src_sel);
			rd(`SCSD_OFF_STAT, d, r);
			chk("stat_lf", `SCSD_LF_RC, d[9:8]);
		end
	endtask

	// RC-only mode holds while the crystal reports ready; every divider is measured.
	task t_div;
		int p, nr, np;
		begin
			wr_ok(`SCSD_OFF_CTRL, 32'h00000002);
			xtal_ready_pin <= 1'b1;
			nr = 0;
			np = 0;
			repeat (8)
			begin
				@(posedge core_clk);
				nr += radio_clk_en;
				np += periph_clk_en;
			end
			chk("radio_cnt", 32'h8, nr);
			chk("periph_cnt", 32'h4, np);
			for (int v = 0; v < 8; v++)
			begin
				wr_ok(`SCSD_OFF_CTRL, (v << 4) | 32'h2);
				cpu_period(p);
				cpu_period(p);
				chk("cpu_period", 1 << ((v > `SCSD_DIV_MAX) ? `SCSD_DIV_MAX : v), p);
			end
			chk("rc_only_src", 1'b0, hs_src_xtal);
			chk("rc_only_xen", 1'b0, hs_xtal_osc_en);
		end
	endtask

	task t_sw;
		begin
			wr_ok(`SCSD_OFF_CTRL, 32'h00000001);
			repeat (30) @(posedge core_clk);
			chk("sw_hold", 1'b0, hs_src_xtal);
			wr_ok(`SCSD_OFF_CTRL, 32'h00000005);
			wait_src(1'b1);
			repeat (2) @(posedge core_clk);
			chk("sw_src", 1'b1, hs_src_xtal);
			chk("sw_gate", 1'b1, hs_clk_gate);
		end
	endtask

	task t_trim;
		begin
			wr_ok(`SCSD_OFF_TRIM, 32'h000000A5);
			repeat (3) @(posedge core_clk);
			rd(`SCSD_OFF_TRIM, d, r);
			chk("trim_rd", 8'hA5, d[7:0]);
			chk("trim_port", 8'hA5, rc_trim);
		end
	endtask

	// Sleep, then wake in auto mode with the crystal not yet ready.
	task t_sleep_wake;
		int n;
		begin
			xtal_ready_pin <= 1'b0;
			wr_ok(`SCSD_OFF_CTRL, 32'h00000008);
			repeat (3) @(posedge core_clk);
			chk("sleep_gate", 1'b0, hs_clk_gate);
			wake_pin <= 1'b1;
			n = 0;
			while (hs_clk_gate !== 1'b1 && n < 40)
			begin
				@(posedge core_clk);
				n++;
			end
			wake_pin <= 1'b0;
			chk("wake_gate", 1'b1, hs_clk_gate);
			chk("wake_src", 1'b0, hs_src_xtal);
			chk("wake_trim", 8'hA5, rc_trim);
			repeat (30) @(posedge core_clk);
			chk("no_ready_src", 1'b0, hs_src_xtal);
			xtal_ready_pin <= 1'b1;
			wait_src(1'b1);
			chk("auto_src", 1'b1, hs_src_xtal);
		end
	endtask

	task t_lf;
		begin
			wr_ok(`SCSD_OFF_LFSEL, 32'h00000003);
			chk("lf_bad", `SCSD_LF_RC, lf_src_sel);
			wr_ok(`SCSD_OFF_LFSEL, {30'h0, `SCSD_LF_XTAL});
			chk("lf_xtal", `SCSD_LF_XTAL, lf_src_sel);
			rd(`SCSD_OFF_LFSEL, d, r);
			chk("lf_lock", 1'b1, d[8]);
			wr_ok(`SCSD_OFF_LFSEL, {30'h0, `SCSD_LF_EXT});
			chk("lf_kept", `SCSD_LF_XTAL, lf_src_sel);
			wr(8'h10, 32'h1, r);
			chk("unmapped_w", `SCSD_RESP_SLVERR, r);
			rd(8'h10, d, r);
			chk("unmapped_r", `SCSD_RESP_SLVERR, r);
			// A second chip reset returns the low-speed choice to RC.
			rst <= 1'b1;
			repeat (2) @(posedge core_clk);
			rst <= 1'b0;
			@(posedge core_clk);
			chk("lf_after_rst", `SCSD_LF_RC, lf_src_sel);
			chk("src_after_rst", 1'b0, hs_src_xtal);
		end
	endtask

	// Hang guard, well beyond the several hundred cycles the tests need.
	initial
	begin
		#300000;
		n_mismatch++;
		tally_and_finish;
	end

	// Main sequence.
	initial
	begin
		rst = 1'b1;
		{xtal_ready_pin, wake_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		t_reset_state;
		t_div;
		t_sw;
		t_trim;
		t_sleep_wake;
		t_lf;
		tally_and_finish;
	end
endmodule
